// ---- aiorb_pkg.sv ----
package aiorb_pkg;

  // Register spaces
  localparam logic SPACE_INPUT = 1'b0;
  localparam logic SPACE_HOLDING = 1'b1;

  // Input register offsets (read-only space)
  localparam logic [15:0] IREG_IN1_SCALED = 16'h0007;
  localparam logic [15:0] IREG_IN2_SCALED = 16'h0008;
  localparam logic [15:0] IREG_IN3_SCALED = 16'h0009;
  localparam logic [15:0] IREG_IN0_RAW = 16'h000a;
  localparam logic [15:0] IREG_IN1_RAW = 16'h000b;
  localparam logic [15:0] IREG_IN2_RAW = 16'h000c;
  localparam logic [15:0] IREG_IN3_RAW = 16'h000d;
  localparam logic [15:0] IREG_OUT0_RANGE = 16'h000e;
  localparam logic [15:0] IREG_OUT1_RANGE = 16'h000f;
  localparam logic [15:0] IREG_OUT0_COUNT = 16'h0010;
  localparam logic [15:0] IREG_OUT1_COUNT = 16'h0011;

  // Holding register offsets (read/write space)
  localparam logic [15:0] HREG_IN_RANGE = 16'h0000;
  localparam logic [15:0] HREG_OUT0_RANGE = 16'h0001;
  localparam logic [15:0] HREG_OUT1_RANGE = 16'h0002;
  localparam logic [15:0] HREG_OUT0_WDOG = 16'h0003;
  localparam logic [15:0] HREG_OUT1_WDOG = 16'h0004;

  // Field layout and values after reset
  localparam int RANGE_LSB = 0;
  localparam int RANGE_W = 2;
  localparam logic [1:0] RANGE_RESET = 2'h0;
  localparam logic [15:0] WDOG_RESET = 16'h0000;

  // Watchdog period codes that disable the timer
  localparam logic [15:0] WDOG_OFF_LOW = 16'h0000;
  localparam logic [15:0] WDOG_OFF_HIGH = 16'hffff;

  // Scaled values and output levels
  localparam logic signed [15:0] SCALED_FULL = 16'sh4e20;
  localparam logic [15:0] LEVEL_MAX = 16'h4e20;
  localparam logic [15:0] LEVEL_KEEP = 16'h7fff;

  // Timing: one watchdog unit is one second
  localparam longint CLK_PERIOD_NS = 100;
  localparam longint WDOG_UNIT_NS = 1000000000;
  localparam int WDOG_TICK_CYCLES = int'(WDOG_UNIT_NS / CLK_PERIOD_NS);

endpackage

// ---- aiorb_wdog.sv ----
`timescale 1ns/1ps
module aiorb_wdog
  import aiorb_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = aiorb_pkg::WDOG_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic [15:0] period_in,
  input wire logic restart_in,
  // Status
  output logic timeout_out,
  output logic expire_out
);

  logic [31:0] tick_r;
  logic [15:0] sec_r;
  logic timeout_r;
  logic expire_r;

  wire enabled = (period_in != WDOG_OFF_LOW) && (period_in != WDOG_OFF_HIGH);
  wire sec_tick = (tick_r == 32'(TICK_CYCLES - 1));
  wire last_sec = (sec_r == period_in - 16'h0001);
  wire running = enabled && !timeout_r && !restart_in;
  wire expire_nxt = running && sec_tick && last_sec;
  wire [31:0] tick_nxt = (!running || sec_tick) ? 32'h0 : tick_r + 32'h1;
  wire [15:0] sec_nxt = (!running || expire_nxt) ? 16'h0 :
                        (sec_tick ? sec_r + 16'h0001 : sec_r);
  // A value write restarts the count and clears the flag; it cannot race
  // an expiry because the restart already stops the countdown.
  wire timeout_nxt = restart_in ? 1'b0 : (timeout_r | expire_nxt);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tick_r <= 32'h0;
      sec_r <= 16'h0;
      timeout_r <= 1'b0;
      expire_r <= 1'b0;
    end else begin
      tick_r <= tick_nxt;
      sec_r <= sec_nxt;
      timeout_r <= timeout_nxt;
      expire_r <= expire_nxt;
    end
  end

  assign timeout_out = timeout_r;
  assign expire_out = expire_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_expire_sets_flag: assert property (expire_out |-> timeout_out)
    else $error("expiry without timeout flag");
  a_restart_clears: assert property (restart_in |=> !timeout_out && !expire_out)
    else $error("restart did not clear watchdog");
  a_disabled_quiet: assert property (!enabled |=> !expire_out)
    else $error("disabled watchdog expired");
  a_expire_one_cycle: assert property (expire_out |=> !expire_out)
    else $error("expiry pulse too long");

endmodule

// ---- aiorb_top.sv ----
`timescale 1ns/1ps
module aiorb_top
  import aiorb_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = aiorb_pkg::WDOG_TICK_CYCLES
) (
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic RESET_N_IN,
  // Register access port
  input wire logic REG_SPACE_IN,
  input wire logic [15:0] REG_ADDR_IN,
  input wire logic REG_RD_IN,
  input wire logic REG_WR_IN,
  input wire logic [15:0] REG_WDATA_IN,
  output logic [15:0] REG_RDATA_OUT,
  output logic REG_ACK_OUT,
  output logic REG_ERR_OUT,
  // Converter data
  input wire logic [2:0][15:0] INPUT_SCALED_IN,
  input wire logic [3:0][15:0] INPUT_RAW_IN,
  input wire logic [1:0][15:0] OUTPUT_COUNT_IN,
  // Output value writes and timeout levels
  input wire logic [1:0] AO_VALUE_WRITE_IN,
  input wire logic [1:0][15:0] AO_TIMEOUT_LEVEL_IN,
  // Configuration and status
  output logic [1:0] INPUT_RANGE_OUT,
  output logic [1:0][1:0] OUTPUT_RANGE_OUT,
  output logic [1:0] WDOG_TIMEOUT_OUT,
  output logic [1:0] AO_FORCE_OUT,
  output logic [1:0][15:0] AO_FORCE_LEVEL_OUT
);

  function automatic logic [15:0] range_word(input logic [1:0] code);
    range_word = {14'h0, code};
  endfunction

  function automatic logic [15:0] clamp_scaled(input logic [15:0] raw);
    logic signed [15:0] v;
    v = $signed(raw);
    if (v > SCALED_FULL) begin
      clamp_scaled = SCALED_FULL;
    end else if (v < -SCALED_FULL) begin
      clamp_scaled = -SCALED_FULL;
    end else begin
      clamp_scaled = raw;
    end
  endfunction

  function automatic logic [15:0] clamp_level(input logic [15:0] lvl);
    if ($signed(lvl) < 0) begin
      clamp_level = 16'h0000;
    end else if (lvl > LEVEL_MAX) begin
      clamp_level = LEVEL_MAX;
    end else begin
      clamp_level = lvl;
    end
  endfunction

  // Configuration registers
  logic [1:0] in_range_r;
  logic [1:0] in_range_nxt;
  logic [1:0][1:0] out_range_r;
  logic [1:0][1:0] out_range_nxt;
  logic [1:0][15:0] wdog_period_r;
  logic [1:0][15:0] wdog_period_nxt;

  // Answer registers
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic ack_r;
  logic err_r;
  logic err_nxt;

  // Watchdog outcome registers
  logic [1:0] force_r;
  logic [1:0][15:0] force_level_r;
  logic [1:0] wd_timeout;
  logic [1:0] wd_expire;

  // Decode
  logic rd_hit;
  logic [15:0] rd_val;
  wire is_hold = (REG_SPACE_IN == SPACE_HOLDING);
  wire both_req = REG_RD_IN && REG_WR_IN;
  wire wr_ok = REG_WR_IN && !REG_RD_IN && is_hold && rd_hit;
  wire wr_in_range = wr_ok && (REG_ADDR_IN == HREG_IN_RANGE);
  wire [1:0] wr_out_range;
  wire [1:0] wr_wdog;

  assign wr_out_range[0] = wr_ok && (REG_ADDR_IN == HREG_OUT0_RANGE);
  assign wr_out_range[1] = wr_ok && (REG_ADDR_IN == HREG_OUT1_RANGE);
  assign wr_wdog[0] = wr_ok && (REG_ADDR_IN == HREG_OUT0_WDOG);
  assign wr_wdog[1] = wr_ok && (REG_ADDR_IN == HREG_OUT1_WDOG);

  // Read mux; an address outside this block answers with an error
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 16'h0000;
    if (is_hold) begin
      case (REG_ADDR_IN)
        HREG_IN_RANGE: rd_val = range_word(in_range_r);
        HREG_OUT0_RANGE: rd_val = range_word(out_range_r[0]);
        HREG_OUT1_RANGE: rd_val = range_word(out_range_r[1]);
        HREG_OUT0_WDOG: rd_val = wdog_period_r[0];
        HREG_OUT1_WDOG: rd_val = wdog_period_r[1];
        default: rd_hit = 1'b0;
      endcase
    end else begin
      case (REG_ADDR_IN)
        IREG_IN1_SCALED: rd_val = clamp_scaled(INPUT_SCALED_IN[0]);
        IREG_IN2_SCALED: rd_val = clamp_scaled(INPUT_SCALED_IN[1]);
        IREG_IN3_SCALED: rd_val = clamp_scaled(INPUT_SCALED_IN[2]);
        IREG_IN0_RAW: rd_val = INPUT_RAW_IN[0];
        IREG_IN1_RAW: rd_val = INPUT_RAW_IN[1];
        IREG_IN2_RAW: rd_val = INPUT_RAW_IN[2];
        IREG_IN3_RAW: rd_val = INPUT_RAW_IN[3];
        IREG_OUT0_RANGE: rd_val = range_word(out_range_r[0]);
        IREG_OUT1_RANGE: rd_val = range_word(out_range_r[1]);
        IREG_OUT0_COUNT: rd_val = OUTPUT_COUNT_IN[0];
        IREG_OUT1_COUNT: rd_val = OUTPUT_COUNT_IN[1];
        default: rd_hit = 1'b0;
      endcase
    end
  end

  // Input registers cannot be written; a write there is refused
  assign err_nxt = both_req || (REG_RD_IN && !rd_hit) ||
                   (REG_WR_IN && (!is_hold || !rd_hit));
  assign rdata_nxt = (REG_RD_IN && !err_nxt) ? rd_val : 16'h0000;

  // Only the two code bits are kept, so the upper bits can never read back
  assign in_range_nxt = wr_in_range ? REG_WDATA_IN[RANGE_LSB +: RANGE_W] :
                        in_range_r;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_out
      assign out_range_nxt[ch] = wr_out_range[ch] ? REG_WDATA_IN[RANGE_LSB +: RANGE_W] :
                                 out_range_r[ch];
      assign wdog_period_nxt[ch] = wr_wdog[ch] ? REG_WDATA_IN : wdog_period_r[ch];

      // A new period starts counting from zero at once
      aiorb_wdog #(
        .TICK_CYCLES(TICK_CYCLES)
      ) u_wdog (
        .clk_in(MCLK_IN),
        .rst_n_in(RESET_N_IN),
        .period_in(wdog_period_r[ch]),
        .restart_in(AO_VALUE_WRITE_IN[ch] || wr_wdog[ch]),
        .timeout_out(wd_timeout[ch]),
        .expire_out(wd_expire[ch])
      );

      wire force_nxt = wd_expire[ch] && (AO_TIMEOUT_LEVEL_IN[ch] != LEVEL_KEEP);
      wire [15:0] level_nxt = force_nxt ? clamp_level(AO_TIMEOUT_LEVEL_IN[ch]) :
                              force_level_r[ch];

      always_ff @(posedge MCLK_IN) begin
        if (!RESET_N_IN) begin
          out_range_r[ch] <= RANGE_RESET;
          wdog_period_r[ch] <= WDOG_RESET;
          force_r[ch] <= 1'b0;
          force_level_r[ch] <= 16'h0000;
        end else begin
          out_range_r[ch] <= out_range_nxt[ch];
          wdog_period_r[ch] <= wdog_period_nxt[ch];
          force_r[ch] <= force_nxt;
          force_level_r[ch] <= level_nxt;
        end
      end
    end
  endgenerate

  always_ff @(posedge MCLK_IN) begin
    if (!RESET_N_IN) begin
      in_range_r <= RANGE_RESET;
      rdata_r <= 16'h0000;
      ack_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      in_range_r <= in_range_nxt;
      rdata_r <= rdata_nxt;
      ack_r <= REG_RD_IN || REG_WR_IN;
      err_r <= err_nxt;
    end
  end

  assign REG_RDATA_OUT = rdata_r;
  assign REG_ACK_OUT = ack_r;
  assign REG_ERR_OUT = err_r;
  assign INPUT_RANGE_OUT = in_range_r;
  assign OUTPUT_RANGE_OUT = out_range_r;
  assign WDOG_TIMEOUT_OUT = wd_timeout;
  assign AO_FORCE_OUT = force_r;
  assign AO_FORCE_LEVEL_OUT = force_level_r;

  // Checks
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  sequence s_rd_input(logic [15:0] addr);
    REG_RD_IN && !REG_WR_IN && (REG_SPACE_IN == SPACE_INPUT) && (REG_ADDR_IN == addr);
  endsequence

  sequence s_wr_holding(logic [15:0] addr);
    REG_WR_IN && !REG_RD_IN && (REG_SPACE_IN == SPACE_HOLDING) && (REG_ADDR_IN == addr);
  endsequence

  // Request kinds are remembered for one cycle so the answer can be judged against them
  wire rd_scaled_req = REG_RD_IN && !is_hold &&
                       (REG_ADDR_IN >= IREG_IN1_SCALED) && (REG_ADDR_IN <= IREG_IN3_SCALED);
  wire rd_in_range_reg = (REG_ADDR_IN == IREG_OUT0_RANGE) || (REG_ADDR_IN == IREG_OUT1_RANGE);
  wire rd_range_req = REG_RD_IN && ((is_hold && (REG_ADDR_IN <= HREG_OUT1_RANGE)) ||
                                    (!is_hold && rd_in_range_reg));
  logic rd_scaled_r;
  logic rd_range_r;

  always_ff @(posedge MCLK_IN) begin
    if (!RESET_N_IN) begin
      rd_scaled_r <= 1'b0;
      rd_range_r <= 1'b0;
    end else begin
      rd_scaled_r <= rd_scaled_req;
      rd_range_r <= rd_range_req;
    end
  end

  wire ack_scaled = REG_ACK_OUT && !REG_ERR_OUT && rd_scaled_r;
  wire ack_range = REG_ACK_OUT && !REG_ERR_OUT && rd_range_r;

  a_ack_follows_req: assert property ((REG_RD_IN || REG_WR_IN) |=> REG_ACK_OUT)
    else $error("request not answered next cycle");
  a_no_idle_ack: assert property (!(REG_RD_IN || REG_WR_IN) |=> !REG_ACK_OUT && !REG_ERR_OUT)
    else $error("answer without request");
  a_scaled_in_bounds: assert property (ack_scaled |->
      ($signed(REG_RDATA_OUT) <= SCALED_FULL) && ($signed(REG_RDATA_OUT) >= -SCALED_FULL))
    else $error("scaled value beyond full scale");
  a_range_high_zero: assert property (ack_range |-> REG_RDATA_OUT[15:2] == 14'h0)
    else $error("unused range bits not zero");
  a_range_readback: assert property (s_rd_input(IREG_OUT1_RANGE) |=>
      REG_RDATA_OUT == range_word($past(out_range_r[1])))
    else $error("output range readback mismatch");
  a_raw_count_read: assert property (s_rd_input(IREG_IN2_RAW) |=>
      REG_RDATA_OUT == $past(INPUT_RAW_IN[2]))
    else $error("raw count read mismatch");
  a_dac_count_read: assert property (s_rd_input(IREG_OUT0_COUNT) |=>
      REG_RDATA_OUT == $past(OUTPUT_COUNT_IN[0]))
    else $error("converter count read mismatch");
  a_out_range_write: assert property (s_wr_holding(HREG_OUT0_RANGE) |=>
      OUTPUT_RANGE_OUT[0] == $past(REG_WDATA_IN[1:0]) && !REG_ERR_OUT)
    else $error("output range write not applied");
  a_in_range_write: assert property (s_wr_holding(HREG_IN_RANGE) |=>
      INPUT_RANGE_OUT == $past(REG_WDATA_IN[1:0]))
    else $error("input range write not applied");
  a_wdog_write: assert property (s_wr_holding(HREG_OUT1_WDOG) |=>
      wdog_period_r[1] == $past(REG_WDATA_IN))
    else $error("watchdog period write not applied");
  a_ro_write_refused: assert property ((REG_WR_IN && REG_SPACE_IN == SPACE_INPUT) |=>
      REG_ERR_OUT && $stable(out_range_r) && $stable(in_range_r))
    else $error("write to read-only space accepted");
  a_force_on_expire: assert property ((wd_expire[0] && AO_TIMEOUT_LEVEL_IN[0] != LEVEL_KEEP)
      |=> AO_FORCE_OUT[0] && AO_FORCE_LEVEL_OUT[0] <= LEVEL_MAX)
    else $error("timeout level not driven");
  a_keep_no_force: assert property ((wd_expire[1] && AO_TIMEOUT_LEVEL_IN[1] == LEVEL_KEEP)
      |=> !AO_FORCE_OUT[1])
    else $error("output changed although level is keep");
  a_force_needs_expire: assert property (AO_FORCE_OUT[0] |-> $past(wd_expire[0]))
    else $error("output forced without expiry");
  a_status_follows: assert property (wd_expire[1] |-> WDOG_TIMEOUT_OUT[1])
    else $error("status bit not set on expiry");
  a_value_write_kicks: assert property (AO_VALUE_WRITE_IN[0] |=> !WDOG_TIMEOUT_OUT[0])
    else $error("value write did not restart watchdog");

endmodule

// ---- aiorb_front_model.sv ----
`timescale 1ns/1ps
module aiorb_front_model #(
  parameter logic [2:0][15:0] SCALED = '0,
  parameter logic [3:0][15:0] RAW = '0,
  parameter logic [1:0][15:0] COUNT = '0,
  parameter logic [1:0][15:0] LEVEL = '0
) (
  // Converter results
  output logic [2:0][15:0] scaled_out,
  output logic [3:0][15:0] raw_out,
  output logic [1:0][15:0] count_out,
  // Timeout levels kept on the client side
  output logic [1:0][15:0] level_out
);
  // Static samples keep expectations exact; a live converter would race the reads
  assign scaled_out = SCALED;
  assign raw_out = RAW;
  assign count_out = COUNT;
  // Levels reach the outputs through their own registers, never the range or period ones
  assign level_out = LEVEL;
endmodule

// ---- analog_io_register_bank_bench.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module analog_io_register_bank_bench;
  import aiorb_pkg::*;
  localparam int TICK = 4;
  localparam logic [2:0][15:0] SCL = {16'h7530, 16'hb1e0, 16'h4e20};
  localparam logic [2:0][15:0] SCL_EXP = {16'h4e20, 16'hb1e0, 16'h4e20};
  localparam logic [3:0][15:0] RAW = {16'hffff, 16'h8001, 16'h1234, 16'h0000};
  localparam logic [1:0][15:0] CNT = {16'h5a5a, 16'ha5a5};
  localparam logic [1:0][15:0] LVL = {16'h7fff, 16'h61a8};
  logic clk = 1'h0, rst_n = 1'h0, sp = 1'h0, rd = 1'h0, wr = 1'h0;
  logic [15:0] addr = 16'h0, wdata = 16'h0, rdata;
  logic ack, err;
  logic [1:0] kick = 2'h0, in_rng, wd_to, force_p;
  logic [1:0][1:0] out_rng;
  logic [2:0][15:0] scl;
  logic [3:0][15:0] raw;
  logic [1:0][15:0] cnt, lvl, force_lvl;
  int miscompares = 0;
  int total_checks = 0;

  always #50 clk = ~clk;

  aiorb_front_model #(.SCALED(SCL), .RAW(RAW), .COUNT(CNT), .LEVEL(LVL)) front (
    .scaled_out(scl), .raw_out(raw), .count_out(cnt), .level_out(lvl));

  aiorb_top #(.TICK_CYCLES(TICK)) dut (
    .MCLK_IN(clk), .RESET_N_IN(rst_n), .REG_SPACE_IN(sp), .REG_ADDR_IN(addr),
    .REG_RD_IN(rd), .REG_WR_IN(wr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
    .REG_ACK_OUT(ack), .REG_ERR_OUT(err), .INPUT_SCALED_IN(scl), .INPUT_RAW_IN(raw),
    .OUTPUT_COUNT_IN(cnt), .AO_VALUE_WRITE_IN(kick), .AO_TIMEOUT_LEVEL_IN(lvl),
    .INPUT_RANGE_OUT(in_rng), .OUTPUT_RANGE_OUT(out_rng), .WDOG_TIMEOUT_OUT(wd_to),
    .AO_FORCE_OUT(force_p), .AO_FORCE_LEVEL_OUT(force_lvl));

  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One-cycle strobe, then wait a bounded number of cycles for the answer
  task automatic acc(input logic s, r, w, input logic [15:0] a, d,
                     output logic [15:0] q, output logic e);
    int n;
    @(negedge clk);
    sp = s;
    rd = r;
    wr = w;
    addr = a;
    wdata = d;
    for (n = 0; n < 4; n++) begin
      @(negedge clk);
      rd = 1'h0;
      wr = 1'h0;
      if (ack === 1'h1) break;
    end
    if (n == 4) begin
      miscompares++;
      tally_and_finish();
    end
    q = rdata;
    e = err;
  endtask

  task automatic rdchk(input logic s, input logic [15:0] a, x);
    logic [15:0] q;
    logic e;
    acc(s, 1'h1, 1'h0, a, 16'h0, q, e);
    `CHK("rd_err", 1'h0, e)
    `CHK("rd_data", x, q)
  endtask

  task automatic wrok(input logic [15:0] a, d);
    logic [15:0] q;
    logic e;
    acc(SPACE_HOLDING, 1'h0, 1'h1, a, d, q, e);
    `CHK("wr_err", 1'h0, e)
  endtask

  task automatic refuse(input logic s, r, w, input logic [15:0] a);
    logic [15:0] q;
    logic e;
    acc(s, r, w, a, 16'hbeef, q, e);
    `CHK("ref_err", 1'h1, e)
    `CHK("ref_data", 16'h0, q)
  endtask

  // Kick a channel, count cycles until its flag rises (300 means never)
  task automatic wd(input int ch, input int exp_n, input logic fp, input logic [15:0] fl);
    int n;
    @(negedge clk);
    kick[ch] = 1'h1;
    for (n = 1; n < 300; n++) begin
      @(negedge clk);
      kick = 2'h0;
      if (n == 1) `CHK("wd_clear", 1'h0, wd_to[ch])
      if (wd_to[ch] === 1'h1) break;
    end
    `CHK("wd_cycles", exp_n, n)
    @(negedge clk);
    `CHK("force", fp, force_p[ch])
    if (fp) `CHK("force_lvl", fl, force_lvl[ch])
  endtask

  initial begin
    int i;
    logic [1:0] c;
    repeat (10) @(negedge clk);
    rst_n = 1'h1;
    for (i = 0; i < 5; i++) rdchk(SPACE_HOLDING, 16'(i), 16'h0);
    `CHK("pins_reset", 6'h0, {in_rng, out_rng})
    for (i = 0; i < 4; i++) begin
      c = i[1:0];
      wrok(HREG_IN_RANGE, {14'h3fff, c});
      `CHK("in_pin", c, in_rng)
      rdchk(SPACE_HOLDING, HREG_IN_RANGE, {14'h0, c});
      wrok(HREG_OUT0_RANGE, {14'h2aaa, c});
      wrok(HREG_OUT1_RANGE, {14'h1555, ~c});
      `CHK("out_pin", {~c, c}, out_rng)
      rdchk(SPACE_HOLDING, HREG_OUT1_RANGE, {14'h0, ~c});
      rdchk(SPACE_INPUT, IREG_OUT0_RANGE, {14'h0, c});
      rdchk(SPACE_INPUT, IREG_OUT1_RANGE, {14'h0, ~c});
    end
    for (i = 0; i < 3; i++) rdchk(SPACE_INPUT, IREG_IN1_SCALED + 16'(i), SCL_EXP[i]);
    for (i = 0; i < 4; i++) rdchk(SPACE_INPUT, IREG_IN0_RAW + 16'(i), RAW[i]);
    for (i = 0; i < 2; i++) rdchk(SPACE_INPUT, IREG_OUT0_COUNT + 16'(i), CNT[i]);
    refuse(SPACE_INPUT, 1'h0, 1'h1, IREG_OUT0_RANGE);
    rdchk(SPACE_INPUT, IREG_OUT0_RANGE, 16'h0003);
    refuse(SPACE_INPUT, 1'h0, 1'h1, IREG_IN0_RAW);
    refuse(SPACE_HOLDING, 1'h1, 1'h0, 16'h0005);
    refuse(SPACE_INPUT, 1'h1, 1'h0, 16'h0006);
    refuse(SPACE_INPUT, 1'h1, 1'h0, 16'h0012);
    refuse(SPACE_HOLDING, 1'h1, 1'h1, HREG_IN_RANGE);
    rdchk(SPACE_HOLDING, HREG_IN_RANGE, 16'h0003);
    wd(0, 300, 1'h0, 16'h0);
    wrok(HREG_OUT0_WDOG, 16'h0001);
    rdchk(SPACE_HOLDING, HREG_OUT0_WDOG, 16'h0001);
    wd(0, TICK + 1, 1'h1, LEVEL_MAX);
    repeat (5) @(negedge clk);
    `CHK("flag_stands", 2'h1, wd_to)
    // Kicks four cycles apart land on the expiry edge, and a restart there cancels it
    repeat (6) begin
      repeat (3) @(negedge clk);
      kick[0] = 1'h1;
      @(negedge clk);
      kick[0] = 1'h0;
      `CHK("kept_alive", 1'h0, wd_to[0])
    end
    wrok(HREG_OUT1_WDOG, 16'h0002);
    wd(1, 2 * TICK + 1, 1'h0, 16'h0);
    wrok(HREG_OUT0_WDOG, 16'hffff);
    wd(0, 300, 1'h0, 16'h0);
    wrok(HREG_OUT0_WDOG, 16'hfffe);
    rdchk(SPACE_HOLDING, HREG_OUT0_WDOG, 16'hfffe);
    tally_and_finish();
  end
endmodule
